// file: rtl/tap_pkg.sv
package tap_pkg;

  // Controller states, Gray coded along the usual walk
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_IDLE = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SHF_DR = 4'h6,
    ST_EX1_DR = 4'h7,
    ST_PAU_DR = 4'h5,
    ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hc,
    ST_SEL_IR = 4'hd,
    ST_CAP_IR = 4'hf,
    ST_SHF_IR = 4'he,
    ST_EX1_IR = 4'ha,
    ST_PAU_IR = 4'hb,
    ST_EX2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } tap_state_t;

  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int PIN_IN_CNT = 4;
  localparam int PIN_OUT_CNT = 4;
  localparam int BSR_LEN = PIN_IN_CNT + PIN_OUT_CNT;

  // Instruction codes
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE = 3'h2;
  localparam logic [2:0] INS_CLAMP = 3'h3;
  localparam logic [2:0] INS_HIGHZ = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;

  // Fixed value loaded into the instruction shifter in Capture-IR
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic [2:0] IR_RESET = INS_IDCODE;
  localparam logic [BSR_LEN-1:0] BSR_RESET = 8'h00;
  localparam logic [ID_LEN-1:0] ID_RESET = 32'h0000_0000;

  // Synchroniser depth on every pin input
  localparam int SYNC_STAGES = 2;

endpackage : tap_pkg

// file: rtl/boundary_scan_tap.sv
`timescale 1ns/1ps
// How it works
// - Controller steps on each test clock rising edge, per mode select level.
// - After reset: Test-Logic-Reset, IDCODE current, identification register selected.
// - Select-DR-Scan goes to Capture-DR on low, Select-IR-Scan on high.
// - Capture-DR parallel-loads the selected register; then Shift-DR or Exit1-DR.
// - Shift-DR shifts selected register one stage toward data out per edge.
// - Exit1-DR goes to Update-DR on high, Pause-DR on low.
// - Pause-DR holds registers; stays on low, Exit2-DR on high.
// - Exit2-DR goes to Update-DR on high, back to Shift-DR on low.
// - Falling edge in Update-DR copies shift path into parallel latches.
// - Select-IR-Scan goes to Capture-IR on low, Test-Logic-Reset on high.
// - Capture-IR loads a fixed value; then Exit1-IR or Shift-IR.
// - Shift-IR shifts the instruction shifter; high leaves to Exit1-IR.
// - Exit1-IR low goes to Pause-IR; Pause-IR stays low, Exit2-IR high.
// - High in Exit1-IR or Exit2-IR enters Update-IR; falling edge latches instruction.
// - Latched instruction is current; Update-IR goes to Run-Test-Idle or Select-DR-Scan.
// - Codes: EXTEST 000, IDCODE 001, SAMPLE 010, CLAMP 011, HIGHZ 100, BYPASS 111.
// - SAMPLE captures pins without disturbing them, shifts data in from data in.
// - BYPASS, CLAMP and HIGHZ use the one-bit bypass register as path.
// - EXTEST drives outputs from boundary latches, captures inputs, shifts boundary register.
// - CLAMP holds outputs at boundary latch values throughout, bypass in path.
// - HIGHZ floats every digital output, bypass in path.
// - IDCODE captures 32-bit identity: bit0 one, maker, device, version fields.
module boundary_scan_tap
  import tap_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = 4'h0, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h5a5a, // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h0aa // Arbitrary value
) (
  input wire logic i_clk, // System clock, 100 MHz
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic i_test_clock, // Test clock pin
  input wire logic i_test_mode_select, // Mode select pin
  input wire logic i_test_data_in, // Serial data in pin
  input wire logic i_test_reset_n, // Test reset pin, active low
  output logic o_test_data_out, // Serial data out
  output logic o_test_data_out_oe, // Data out driven
  input wire logic [PIN_IN_CNT-1:0] i_pin_in, // Digital input pins
  input wire logic [PIN_OUT_CNT-1:0] i_core_out, // Core values for output pins
  output logic [PIN_OUT_CNT-1:0] o_pin_out, // Output pin values
  output logic [PIN_OUT_CNT-1:0] o_pin_oe, // Output pin enables
  output logic [2:0] o_instruction // Current instruction
);

  // Two-stage synchronisers for all pins
  localparam int SW = 4 + PIN_IN_CNT;
  logic [SW-1:0] meta_ff;
  logic [SW-1:0] sync_ff;
  logic tck_prev_ff;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
      tck_prev_ff <= 1'b0;
    end else begin
      meta_ff <= {i_pin_in, i_test_reset_n, i_test_data_in, i_test_mode_select, i_test_clock};
      sync_ff <= meta_ff;
      tck_prev_ff <= sync_ff[0];
    end
  end

  logic tck_s, tms_s, tdi_s, trst_n_s, tck_rise, tck_fall;
  logic [PIN_IN_CNT-1:0] pin_in_s;
  assign tck_s = sync_ff[0];
  assign tms_s = sync_ff[1];
  assign tdi_s = sync_ff[2];
  assign trst_n_s = sync_ff[3];
  assign pin_in_s = sync_ff[SW-1:4];
  // Edges found on the sampled test clock
  assign tck_rise = tck_s & ~tck_prev_ff;
  assign tck_fall = ~tck_s & tck_prev_ff;

  tap_state_t state_ff, nxt_state;
  logic [2:0] ir_sr_ff, nxt_ir_sr, ir_ff, nxt_ir;
  logic byp_ff, nxt_byp;
  logic [ID_LEN-1:0] id_sr_ff, nxt_id_sr;
  logic [BSR_LEN-1:0] bsr_sr_ff, nxt_bsr_sr, bsr_upd_ff, nxt_bsr_upd;
  logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;
  logic [PIN_OUT_CNT-1:0] pin_out_ff, nxt_pin_out, pin_oe_ff, nxt_pin_oe;
  logic sel_bsr, sel_id;
  logic [ID_LEN-1:0] id_value;

  assign id_value = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  // Register chosen by the current instruction; all others fall back to bypass
  assign sel_bsr = (ir_ff == INS_EXTEST) || (ir_ff == INS_SAMPLE);
  assign sel_id = (ir_ff == INS_IDCODE);

  // Controller walk
  always_comb begin
    nxt_state = state_ff;
    if (!trst_n_s) begin
      nxt_state = ST_RESET;
    end else if (tck_rise) begin
      unique case (state_ff)
        ST_RESET: nxt_state = tms_s ? ST_RESET : ST_IDLE;
        ST_IDLE: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SHF_DR;
        ST_SHF_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SHF_DR;
        ST_EX1_DR: nxt_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: nxt_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: nxt_state = tms_s ? ST_UPD_DR : ST_SHF_DR;
        ST_UPD_DR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: nxt_state = tms_s ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SHF_IR;
        ST_SHF_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SHF_IR;
        ST_EX1_IR: nxt_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: nxt_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: nxt_state = tms_s ? ST_UPD_IR : ST_SHF_IR;
        ST_UPD_IR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
      endcase
    end
  end

  // Shift paths act on rising edges; latches update on falling edges
  always_comb begin
    nxt_ir_sr = ir_sr_ff;
    nxt_ir = ir_ff;
    nxt_byp = byp_ff;
    nxt_id_sr = id_sr_ff;
    nxt_bsr_sr = bsr_sr_ff;
    nxt_bsr_upd = bsr_upd_ff;
    nxt_tdo = tdo_ff;
    nxt_tdo_oe = tdo_oe_ff;
    if (tck_rise) begin
      unique case (state_ff)
        ST_CAP_IR: nxt_ir_sr = IR_CAPTURE;
        ST_SHF_IR: nxt_ir_sr = {tdi_s, ir_sr_ff[2:1]};
        ST_CAP_DR: begin
          if (sel_id) begin
            nxt_id_sr = id_value;
          end else if (sel_bsr) begin
            nxt_bsr_sr = {i_core_out, pin_in_s};
          end else begin
            nxt_byp = 1'b0;
          end
        end
        ST_SHF_DR: begin
          if (sel_id) begin
            nxt_id_sr = {tdi_s, id_sr_ff[ID_LEN-1:1]};
          end else if (sel_bsr) begin
            nxt_bsr_sr = {tdi_s, bsr_sr_ff[BSR_LEN-1:1]};
          end else begin
            nxt_byp = tdi_s;
          end
        end
        default: ; // Pause, exit and select states hold every register
      endcase
    end
    if (tck_fall) begin
      // Data out changes on the falling edge so the tester samples it stable
      nxt_tdo_oe = (state_ff == ST_SHF_IR) || (state_ff == ST_SHF_DR);
      if (state_ff == ST_SHF_IR) begin
        nxt_tdo = ir_sr_ff[0];
      end else if (sel_id) begin
        nxt_tdo = id_sr_ff[0];
      end else if (sel_bsr) begin
        nxt_tdo = bsr_sr_ff[0];
      end else begin
        nxt_tdo = byp_ff;
      end
      if (state_ff == ST_UPD_IR) begin
        nxt_ir = ir_sr_ff;
      end
      if (state_ff == ST_UPD_DR && sel_bsr) begin
        nxt_bsr_upd = bsr_sr_ff;
      end
    end
    if (state_ff == ST_RESET) begin
      nxt_ir = INS_IDCODE;
    end
  end

  // Pin muxing; normal operation unless a test instruction takes the pins
  always_comb begin
    nxt_pin_out = i_core_out;
    nxt_pin_oe = '1;
    if (ir_ff == INS_EXTEST || ir_ff == INS_CLAMP) begin
      nxt_pin_out = bsr_upd_ff[BSR_LEN-1:PIN_IN_CNT];
    end else if (ir_ff == INS_HIGHZ) begin
      nxt_pin_oe = '0;
    end
  end

  // Every register loads on each system clock edge; reset is synchronous
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= ST_RESET;
      ir_sr_ff <= IR_RESET;
      ir_ff <= IR_RESET;
      byp_ff <= 1'b0;
      id_sr_ff <= ID_RESET;
      bsr_sr_ff <= BSR_RESET;
      bsr_upd_ff <= BSR_RESET;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ir_sr_ff <= nxt_ir_sr;
      ir_ff <= nxt_ir;
      byp_ff <= nxt_byp;
      id_sr_ff <= nxt_id_sr;
      bsr_sr_ff <= nxt_bsr_sr;
      bsr_upd_ff <= nxt_bsr_upd;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // Outputs come straight from flops, so no glitch reaches a pin
  assign o_test_data_out = tdo_ff;
  assign o_test_data_out_oe = tdo_oe_ff;
  assign o_pin_out = pin_out_ff;
  assign o_pin_oe = pin_oe_ff;
  assign o_instruction = ir_ff;

  // Checks on the controller and its registers
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_test_reset_force: assert property (!trst_n_s |=> state_ff == ST_RESET)
    else $error("test reset did not force reset state");

  // Controller steps, each judged one cycle after a detected test clock rise
  a_sel_dr_step: assert property (tck_rise && trst_n_s && state_ff == ST_SEL_DR
    |=> state_ff == ($past(tms_s) ? ST_SEL_IR : ST_CAP_DR))
    else $error("bad step from select dr");
  a_cap_dr_step: assert property (tck_rise && trst_n_s && state_ff == ST_CAP_DR
    |=> state_ff == ($past(tms_s) ? ST_EX1_DR : ST_SHF_DR))
    else $error("bad step from capture dr");
  a_exit1_dr_step: assert property (tck_rise && trst_n_s && state_ff == ST_EX1_DR
    |=> state_ff == ($past(tms_s) ? ST_UPD_DR : ST_PAU_DR))
    else $error("bad step from exit1 dr");
  a_exit2_dr_step: assert property (tck_rise && trst_n_s && state_ff == ST_EX2_DR
    |=> state_ff == ($past(tms_s) ? ST_UPD_DR : ST_SHF_DR))
    else $error("bad step from exit2 dr");
  a_sel_ir_step: assert property (tck_rise && trst_n_s && state_ff == ST_SEL_IR
    |=> state_ff == ($past(tms_s) ? ST_RESET : ST_CAP_IR) && $stable(ir_ff))
    else $error("bad step from select ir");
  a_exit1_ir_step: assert property (tck_rise && trst_n_s && state_ff == ST_EX1_IR
    |=> state_ff == ($past(tms_s) ? ST_UPD_IR : ST_PAU_IR))
    else $error("bad step from exit1 ir");
  a_exit2_ir_loop: assert property (tck_rise && trst_n_s && state_ff == ST_EX2_IR && !tms_s
    |=> state_ff == ST_SHF_IR)
    else $error("exit2 ir did not return to shift ir");
  a_update_ir_step: assert property (tck_rise && trst_n_s && state_ff == ST_UPD_IR
    |=> state_ff == ($past(tms_s) ? ST_SEL_DR : ST_IDLE))
    else $error("bad step from update ir");
  a_pause_dr_hold: assert property (tck_rise && trst_n_s && state_ff == ST_PAU_DR && !tms_s
    |=> state_ff == ST_PAU_DR && $stable(bsr_sr_ff) && $stable(id_sr_ff))
    else $error("pause dr moved or shifted");
  a_pause_ir_hold: assert property (tck_rise && trst_n_s && state_ff == ST_PAU_IR && !tms_s
    |=> state_ff == ST_PAU_IR && $stable(ir_sr_ff) && $stable(ir_ff))
    else $error("pause ir moved or shifted");

  // Register contents, data out and pins
  a_id_capture: assert property (tck_rise && state_ff == ST_CAP_DR && ir_ff == INS_IDCODE
    |=> id_sr_ff[0] && id_sr_ff[ID_LEN-1:1] == {ID_VERSION, ID_PART, ID_MAKER})
    else $error("identity not captured");
  a_id_shift: assert property (tck_rise && state_ff == ST_SHF_DR && ir_ff == INS_IDCODE
    |=> id_sr_ff == {$past(tdi_s), $past(id_sr_ff[ID_LEN-1:1])})
    else $error("identity shift wrong");
  a_sample_capture: assert property (tck_rise && state_ff == ST_CAP_DR
    && (ir_ff == INS_SAMPLE || ir_ff == INS_EXTEST) |=> bsr_sr_ff == $past({i_core_out, pin_in_s}))
    else $error("boundary capture wrong");
  a_bypass_capture: assert property (tck_rise && state_ff == ST_CAP_DR
    && (ir_ff == INS_BYPASS || ir_ff == INS_CLAMP || ir_ff == INS_HIGHZ) |=> !byp_ff)
    else $error("bypass not cleared in capture");
  a_ir_capture: assert property (tck_rise && state_ff == ST_CAP_IR |=> ir_sr_ff == IR_CAPTURE)
    else $error("instruction capture wrong");
  a_ir_update: assert property (tck_fall && state_ff == ST_UPD_IR |=> ir_ff == $past(ir_sr_ff))
    else $error("instruction not latched in update ir");
  a_reset_idcode: assert property (state_ff == ST_RESET |=> ir_ff == INS_IDCODE)
    else $error("reset state lacks idcode");
  a_bsr_update: assert property (tck_fall && state_ff == ST_UPD_DR
    && (ir_ff == INS_SAMPLE || ir_ff == INS_EXTEST) |=> bsr_upd_ff == $past(bsr_sr_ff))
    else $error("boundary latch not updated");
  a_data_out_en: assert property (tck_fall
    |=> o_test_data_out_oe == ($past(state_ff) == ST_SHF_IR || $past(state_ff) == ST_SHF_DR))
    else $error("data out enable wrong");
  a_extest_drive: assert property (ir_ff == INS_EXTEST ##1 ir_ff == INS_EXTEST
    |-> o_pin_out == $past(bsr_upd_ff[BSR_LEN-1:PIN_IN_CNT]))
    else $error("extest outputs not from latches");
  a_highz_float: assert property (ir_ff == INS_HIGHZ ##1 ir_ff == INS_HIGHZ |-> o_pin_oe == '0)
    else $error("outputs driven under highz");
  a_clamp_steady: assert property (ir_ff == INS_CLAMP ##1 ir_ff == INS_CLAMP ##1 ir_ff == INS_CLAMP
    |-> $stable(o_pin_out))
    else $error("clamped outputs changed");

  // Main scenarios the bench is expected to reach
  c_id_shift: cover property (state_ff == ST_SHF_DR && ir_ff == INS_IDCODE ##1 state_ff == ST_EX1_DR);
  c_ir_update: cover property (state_ff == ST_UPD_IR && tck_fall ##1 ir_ff == INS_BYPASS);
  c_extest_drive: cover property (ir_ff == INS_EXTEST && state_ff == ST_UPD_DR ##1 tck_fall);
  c_pause_ir: cover property (state_ff == ST_PAU_IR ##1 state_ff == ST_EX2_IR);

endmodule : boundary_scan_tap

// file: verif/tap_tester.sv
`timescale 1ns/1ps
// Test controller model; between frames the clock stands still and pins sit at pull-up level
module tap_tester (
  input wire logic i_clk, // Paces the link
  input wire logic i_test_data_out, // Serial data from the block
  output logic o_test_clock, // Test clock, 160 ns period
  output logic o_test_mode_select, // Mode select
  output logic o_test_data_in, // Serial data to the block
  output logic o_test_reset_n // Test reset, active low
);
  // Pull-up levels at power up
  initial begin
    o_test_clock = 1'b0;
    o_test_mode_select = 1'b1;
    o_test_data_in = 1'b1;
    o_test_reset_n = 1'b1;
  end

  // One link cycle: pins change at the fall, data out read just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge i_clk);
    o_test_clock <= 1'b0;
    o_test_mode_select <= tms;
    o_test_data_in <= tdi;
    repeat (8) @(posedge i_clk);
    tdo = i_test_data_out;
    o_test_clock <= 1'b1;
    repeat (7) @(posedge i_clk);
  endtask : step

  // Scan from idle back to idle; pa names the bit after which the scan pauses
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input int pa,
                      output logic [31:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == pa, din[i], t);
      dout[i] = t;
      if (i == pa) begin
        // Data in shows the inverse of its last bit so a stale sample is caught
        step(1'b0, ~din[i], t);
        step(1'b0, ~din[i], t);
        step(1'b1, ~din[i], t);
        step(1'b0, ~din[i], t);
      end
    end
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    @(posedge i_clk);
    o_test_clock <= 1'b0;
    o_test_mode_select <= 1'b1;
    o_test_data_in <= 1'b1;
  endtask : scan

  // Test reset held 120 ns, above the minimum low width
  task automatic pulse_reset();
    @(posedge i_clk);
    o_test_reset_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    o_test_reset_n <= 1'b1;
    repeat (8) @(posedge i_clk);
  endtask : pulse_reset
endmodule : tap_tester

// file: verif/tb_top.sv
`timescale 1ns/1ps
// Bench: link model on the test pins, queue model of the selected shifter
module tb_top;
  import tap_pkg::*;
  localparam logic [3:0] VER = 4'h3; // Arbitrary value
  localparam logic [15:0] PART = 16'h1234; // Arbitrary value
  localparam logic [10:0] MAKER = 11'h155; // Arbitrary value
  logic i_clk, i_reset, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [3:0] pin_in, core_out, pin_out, pin_oe, exp_pins;
  logic [2:0] instr;
  logic [7:0] latch, pat;
  logic [31:0] got;
  logic [2:0] codes [5] = '{INS_EXTEST, INS_CLAMP, INS_HIGHZ, 3'h5, INS_BYPASS};
  int n_fail, n_tests, seed, n_oe;

  // 100 MHz system clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  boundary_scan_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_test_clock(tck), .i_test_mode_select(tms),
    .i_test_data_in(tdi), .i_test_reset_n(trst_n), .o_test_data_out(tdo),
    .o_test_data_out_oe(tdo_oe), .i_pin_in(pin_in), .i_core_out(core_out),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_instruction(instr));

  tap_tester u_tester (.i_clk(i_clk), .i_test_data_out(tdo), .o_test_clock(tck),
    .o_test_mode_select(tms), .o_test_data_in(tdi), .o_test_reset_n(trst_n));

  // Cycles with data out enabled; each shifted bit keeps it up one 160 ns link period
  always @(posedge i_clk) begin
    if (tdo_oe === 1'b1) n_oe++;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_word

  task automatic check_pins(input string what, input logic [3:0] exp, input logic [3:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_pins

  // Queue stands for the selected shifter: captured bits leave first, data in joins the tail
  task automatic scan_check(input string what, input logic ir, input int len, input logic [31:0] cap,
                            input int n, input logic [31:0] din, input int pa);
    logic q[$];
    logic [31:0] exp;
    exp = '0;
    for (int i = 0; i < len; i++) q.push_back(cap[i]);
    for (int i = 0; i < n; i++) begin
      exp[i] = q.pop_front();
      q.push_back(din[i]);
    end
    n_oe = 0;
    u_tester.scan(ir, n, din, pa, got);
    repeat (8) @(posedge i_clk);
    check_word(what, exp, got);
    check_word("oe_cycles", 32'(16 * n), 32'(n_oe));
  endtask : scan_check

  task automatic load_ir(input logic [2:0] code, input int pa);
    scan_check("capture_ir", 1'b1, 3, {29'h0, IR_CAPTURE}, 3, {29'h0, code}, pa);
    check_pins("instruction", {1'b0, code}, {1'b0, instr});
  endtask : load_ir

  // Main sequence
  initial begin
    seed = 38;
    n_fail = 0;
    n_tests = 0;
    i_reset = 1'b1;
    pin_in = 4'h0;
    core_out = 4'h0;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    pin_in <= $random(seed);
    core_out <= $random(seed);
    repeat (6) @(posedge i_clk);
    check_pins("instruction", {1'b0, INS_IDCODE}, {1'b0, instr});
    u_tester.step(1'b0, 1'b1, got[0]);
    scan_check("idcode", 1'b0, 32, {VER, PART, MAKER, 1'b1}, 32, $random(seed), 11);
    load_ir(INS_SAMPLE, 0);
    pat = $random(seed);
    scan_check("sample", 1'b0, 8, {core_out, pin_in}, 8, pat, 3);
    check_pins("pins", core_out, pin_out);
    latch = pat;
    // Remaining instructions plus unused code 5; core values change so a held output shows
    foreach (codes[k]) begin
      load_ir(codes[k], -1);
      if (codes[k] == INS_EXTEST) check_pins("preload", latch[7:4], pin_out);
      core_out <= $random(seed);
      pin_in <= $random(seed);
      pat = $random(seed);
      repeat (4) @(posedge i_clk);
      if (codes[k] == INS_EXTEST) begin
        scan_check("extest", 1'b0, 8, {core_out, pin_in}, 8, pat, -1);
        latch = pat;
      end else begin
        scan_check("bypass", 1'b0, 1, 32'h0, 8, pat, -1);
      end
      check_pins("enables", (codes[k] == INS_HIGHZ) ? 4'h0 : 4'hf, pin_oe);
      if (codes[k] != INS_HIGHZ) begin
        exp_pins = (codes[k] == INS_EXTEST || codes[k] == INS_CLAMP) ? latch[7:4] : core_out;
        check_pins("pins", exp_pins, pin_out);
      end
    end
    repeat (3) u_tester.step(1'b1, 1'b1, got[0]);
    repeat (6) @(posedge i_clk);
    check_pins("instruction", {1'b0, INS_IDCODE}, {1'b0, instr});
    u_tester.step(1'b0, 1'b1, got[0]);
    load_ir(INS_BYPASS, -1);
    u_tester.pulse_reset();
    check_pins("instruction", {1'b0, INS_IDCODE}, {1'b0, instr});
    give_verdict();
  end

  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    give_verdict();
  end
endmodule : tb_top
